// ---- hw/srbs_top.sv ----
`timescale 1ns/100ps
module srbs_top (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic encHasZeroIndex,
  output logic signed [31:0] speedRef,
  output logic signed [15:0] currentOffset,
  output logic holdTorque,
  output logic regulateEn,
  output logic powerStageOn,
  output logic brake_output_pin,
  output logic cogCompEn,
  output logic cogMapActive
);
  import srbs_pkg::*;

  typedef struct packed {
    logic awDone;
    logic wDone;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [31:0] ctrl;
    logic [31:0] accCw;
    logic [31:0] decCw;
    logic [31:0] accCcw;
    logic [31:0] decCcw;
    logic [31:0] jerk;
    logic [31:0] brkDec;
    logic [31:0] brkSpd;
    logic [15:0] tEng;
    logic [15:0] tRel;
    logic signed [15:0] curOfs;
    logic signed [31:0] target;
    logic signed [31:0] spdRef;
    logic signed [31:0] accel;
    logic [16:0] msDiv;
    logic [15:0] msCnt;
    logic cogAbort;
    srbs_state_e st;
    logic brakePin;
    logic hold;
    logic regEn;
    logic pwr;
    logic awRdy, wRdy, arRdy;
  } srbs_s;

  srbs_s state_reg;
  srbs_s state_next;

  // Byte-lane merge used for every writable word except the brake times and current offset
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      r[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
    return r;
  endfunction
  // Clamp a brake time into its allowed window
  function automatic logic [15:0] clampMs(input logic [15:0] v);
    return (v < 16'(T_MIN_MS)) ? 16'(T_MIN_MS) : ((v > 16'(T_MAX_MS)) ? 16'(T_MAX_MS) : v);
  endfunction
  // Magnitude of a signed word
  function automatic logic [31:0] absv(input logic signed [31:0] v);
    return v[31] ? 32'(-v) : 32'(v);
  endfunction

  logic msTick;
  logic signed [31:0] goal;
  logic signed [31:0] err;
  logic [31:0] rate;
  logic signed [31:0] step;
  logic signed [31:0] aLim;
  logic ccw;
  logic accelerating;
  logic speedCtl;
  logic brakeFn;
  logic wrFire;
  logic [31:0] rdVal;
  logic rdOk;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    msTick = (state_reg.msDiv == CYC_PER_MS - 17'd1);
    speedCtl = state_reg.ctrl[CB_SPEED_CTL];
    brakeFn = state_reg.ctrl[CB_BRAKE_EN] & speedCtl;
    state_next.msDiv = msTick ? 17'd0 : state_reg.msDiv + 17'd1;

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && !state_reg.awDone && !state_reg.bValid) begin
      state_next.awDone = 1'b1;
      state_next.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state_reg.wDone && !state_reg.bValid) begin
      state_next.wDone = 1'b1;
      state_next.wData = s_axi_wdata;
      state_next.wStrb = s_axi_wstrb;
    end
    wrFire = state_reg.awDone && state_reg.wDone && !state_reg.bValid;
    if (wrFire) begin
      state_next.awDone = 1'b0;
      state_next.wDone = 1'b0;
      state_next.bValid = 1'b1;
      state_next.bResp = AXI_OKAY;
      case (state_reg.awAddr)
        SRBS_CTRL: state_next.ctrl = merge(state_reg.ctrl, state_reg.wData, state_reg.wStrb);
        SRBS_ACC_CW: state_next.accCw = merge(state_reg.accCw, state_reg.wData, state_reg.wStrb);
        SRBS_DEC_CW: state_next.decCw = merge(state_reg.decCw, state_reg.wData, state_reg.wStrb);
        SRBS_ACC_CCW: state_next.accCcw = merge(state_reg.accCcw, state_reg.wData, state_reg.wStrb);
        SRBS_DEC_CCW: state_next.decCcw = merge(state_reg.decCcw, state_reg.wData, state_reg.wStrb);
        SRBS_JERK: state_next.jerk = merge(state_reg.jerk, state_reg.wData, state_reg.wStrb);
        SRBS_BRK_DEC: state_next.brkDec = merge(state_reg.brkDec, state_reg.wData, state_reg.wStrb);
        SRBS_BRK_SPD: state_next.brkSpd = merge(state_reg.brkSpd, state_reg.wData, state_reg.wStrb);
        SRBS_T_ENG: state_next.tEng = clampMs(state_reg.wData[15:0]);
        SRBS_T_REL: state_next.tRel = clampMs(state_reg.wData[15:0]);
        SRBS_CUR_OFS: state_next.curOfs = state_reg.wData[15:0];
        SRBS_TARGET: state_next.target = merge(state_reg.target, state_reg.wData, state_reg.wStrb);
        default: state_next.bResp = AXI_SLVERR;
      endcase
    end
    if (state_reg.bValid && s_axi_bready) begin
      state_next.bValid = 1'b0;
    end

    // Read channel: one read at a time, answer the cycle after the take
    rdOk = 1'b1;
    case (s_axi_araddr)
      SRBS_CTRL: rdVal = state_reg.ctrl;
      SRBS_ACC_CW: rdVal = state_reg.accCw;
      SRBS_DEC_CW: rdVal = state_reg.decCw;
      SRBS_ACC_CCW: rdVal = state_reg.accCcw;
      SRBS_DEC_CCW: rdVal = state_reg.decCcw;
      SRBS_JERK: rdVal = state_reg.jerk;
      SRBS_BRK_DEC: rdVal = state_reg.brkDec;
      SRBS_BRK_SPD: rdVal = state_reg.brkSpd;
      SRBS_T_ENG: rdVal = {16'h0000, state_reg.tEng};
      SRBS_T_REL: rdVal = {16'h0000, state_reg.tRel};
      SRBS_CUR_OFS: rdVal = {{16{state_reg.curOfs[15]}}, state_reg.curOfs};
      SRBS_TARGET: rdVal = state_reg.target;
      SRBS_STATUS: rdVal = {24'h000000, state_reg.cogAbort, state_reg.st == SRBS_ENGAGE,
                            state_reg.st == SRBS_STOPPING, state_reg.st == SRBS_RUN,
                            state_reg.st == SRBS_RELEASE, state_reg.pwr, state_reg.regEn,
                            state_reg.brakePin};
      SRBS_REFOUT: rdVal = state_reg.spdRef;
      default: begin
        rdVal = 32'h00000000;
        rdOk = 1'b0;
      end
    endcase
    if (s_axi_arvalid && !state_reg.rValid) begin
      state_next.rValid = 1'b1;
      state_next.rData = rdVal;
      state_next.rResp = rdOk ? AXI_OKAY : AXI_SLVERR;
    end else if (state_reg.rValid && s_axi_rready) begin
      state_next.rValid = 1'b0;
    end

    // abort mapping without index; sticky until the map bit drops
    if (state_reg.ctrl[CB_COG_MAP] && !encHasZeroIndex) begin
      state_next.cogAbort = 1'b1;
    end else if (!state_reg.ctrl[CB_COG_MAP]) begin
      state_next.cogAbort = 1'b0;
    end

    // Sequencer; decisions use the ramped reference only
    goal = state_reg.target;
    case (state_reg.st)
      SRBS_OFF: begin
        goal = 32'sd0;
        if (state_reg.ctrl[CB_SWITCH_ON]) begin
          state_next.pwr = 1'b1;
          state_next.msCnt = 16'd0;
          // release phase only with brake function
          state_next.st = brakeFn ? SRBS_RELEASE : SRBS_RUN;
          state_next.brakePin = brakeFn;
          state_next.regEn = !brakeFn;
          state_next.hold = brakeFn;
        end
      end
      SRBS_RELEASE: begin
        goal = 32'sd0;
        if (msTick) begin
          state_next.msCnt = state_reg.msCnt + 16'd1;
        end
        if (state_reg.msCnt >= state_reg.tRel) begin
          state_next.st = SRBS_RUN;
          state_next.hold = 1'b0;
          state_next.regEn = 1'b1;
        end
      end
      SRBS_RUN: begin
        if (!state_reg.ctrl[CB_SWITCH_ON]) begin
          state_next.st = brakeFn ? SRBS_STOPPING : SRBS_OFF;
          if (!brakeFn) begin
            state_next.pwr = 1'b0;
            state_next.regEn = 1'b0;
            state_next.spdRef = 32'sd0;
            state_next.accel = 32'sd0;
          end
        end
      end
      SRBS_STOPPING: begin
        goal = 32'sd0;
        if (absv(state_reg.spdRef) <= state_reg.brkSpd) begin
          state_next.st = SRBS_ENGAGE;
          state_next.brakePin = 1'b0;
          state_next.hold = 1'b1;
          state_next.regEn = 1'b0;
          state_next.msCnt = 16'd0;
        end
      end
      SRBS_ENGAGE: begin
        goal = 32'sd0;
        if (msTick) begin
          state_next.msCnt = state_reg.msCnt + 16'd1;
        end
        if (state_reg.msCnt >= state_reg.tEng) begin
          state_next.st = SRBS_OFF;
          state_next.hold = 1'b0;
          state_next.regEn = 1'b0;
          state_next.pwr = 1'b0;
          state_next.spdRef = 32'sd0;
          state_next.accel = 32'sd0;
        end
      end
      default: state_next.st = SRBS_OFF;
    endcase

    ccw = state_reg.spdRef[31] || (state_reg.spdRef == 32'sd0 && goal[31]);
    err = goal - state_reg.spdRef;
    accelerating = (goal[31] == state_reg.spdRef[31]) ? (absv(goal) > absv(state_reg.spdRef))
                                                       : (state_reg.spdRef == 32'sd0);
    if (accelerating) begin
      rate = ccw ? state_reg.accCcw : state_reg.accCw;
    end else begin
      rate = ccw ? state_reg.decCcw : state_reg.decCw;
    end
    if (state_reg.st == SRBS_STOPPING && absv(state_reg.spdRef) > state_reg.brkSpd) begin
      rate = state_reg.brkDec;
    end
    step = 32'(rate / 32'(TICKS_PER_S));
    if (step == 32'sd0) begin
      step = 32'sd1;
    end
    aLim = 32'(state_reg.jerk / 32'(TICKS_PER_S * TICKS_PER_S));
    if (aLim == 32'sd0) begin
      aLim = 32'sd1;
    end

    if (state_reg.st == SRBS_RUN || state_reg.st == SRBS_STOPPING) begin
      if (!(state_reg.ctrl[CB_RAMP_EN] && speedCtl)) begin
        state_next.spdRef = goal;
        state_next.accel = 32'sd0;
      end else if (msTick) begin
        if (state_reg.ctrl[CB_SPROF]) begin
          if (err > state_reg.accel && state_reg.accel < step) begin
            state_next.accel = state_reg.accel + aLim;
          end else if (err < state_reg.accel && state_reg.accel > -step) begin
            state_next.accel = state_reg.accel - aLim;
          end
          if (state_next.accel > step) begin
            state_next.accel = step;
          end
          if (state_next.accel < -step) begin
            state_next.accel = -step;
          end
          state_next.spdRef = state_reg.spdRef + state_next.accel;
          if ((err >= 32'sd0 && state_next.accel >= err) ||
              (err <= 32'sd0 && state_next.accel <= err)) begin
            state_next.spdRef = goal;
            state_next.accel = 32'sd0;
          end
        end else if (err > step) begin
          state_next.spdRef = state_reg.spdRef + step;
        end else if (err < -step) begin
          state_next.spdRef = state_reg.spdRef - step;
        end else begin
          state_next.spdRef = goal;
        end
      end
    end
    // Readys registered so every bus output leaves a flop
    state_next.awRdy = !state_next.awDone && !state_next.bValid;
    state_next.wRdy = !state_next.wDone && !state_next.bValid;
    state_next.arRdy = !state_next.rValid;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronous reset; brake engaged after reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.st <= SRBS_OFF;
      state_reg.tEng <= 16'(T_MIN_MS);
      state_reg.tRel <= 16'(T_MIN_MS);
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic outPinNext;
  // first output carries brake when assigned; high releases
  assign outPinNext = state_next.ctrl[CB_PIN_BRAKE] ? state_next.brakePin
                                                    : state_next.ctrl[CB_PIN_LEVEL];
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      brake_output_pin <= 1'b0;
      currentOffset <= 16'sd0;
      cogCompEn <= 1'b0;
      cogMapActive <= 1'b0;
    end else begin
      brake_output_pin <= outPinNext;
      currentOffset <= (state_next.st == SRBS_RELEASE) ? state_next.curOfs : 16'sd0;
      cogCompEn <= state_next.ctrl[CB_COG_EN];
      cogMapActive <= state_next.ctrl[CB_COG_MAP] && !state_next.cogAbort;
    end
  end

  // Outputs taken straight from the state flops
  assign s_axi_awready = state_reg.awRdy;
  assign s_axi_wready = state_reg.wRdy;
  assign s_axi_bvalid = state_reg.bValid;
  assign s_axi_bresp = state_reg.bResp;
  assign s_axi_arready = state_reg.arRdy;
  assign s_axi_rvalid = state_reg.rValid;
  assign s_axi_rdata = state_reg.rData;
  assign s_axi_rresp = state_reg.rResp;
  assign speedRef = state_reg.spdRef;
  assign holdTorque = state_reg.hold;
  assign regulateEn = state_reg.regEn;
  assign powerStageOn = state_reg.pwr;
endmodule

// ---- inc/srbs_pkg.sv ----
// How it works
// - Ramps act only under speed control
// - Reference is ramped with ramp enabled, else stepped
// - Separate CW and CCW accel/decel rates
// - S-profile limits acceleration change by jerk
// - Switch-off with brake function ramps to stop, then brakes
// - Brake pin high releases, low engages
// - Brake engage/release times 10 to 2000 ms
// - Brake decel rate used only above threshold
// - Hold torque until engage time expires
// - Hold torque through release time, then regulate
// - Signed pre-torque offset during release
// - Stop sequence follows reference, not measurement
// - No brake sequencing under torque control
// - First digital output assignable to brake
// - Cogging mapping aborts without zero index
// - Cogging compensation switchable over fieldbus
package srbs_pkg;
  // Register byte offsets
  localparam logic [7:0] SRBS_CTRL = 8'h00;
  localparam logic [7:0] SRBS_ACC_CW = 8'h04;
  localparam logic [7:0] SRBS_DEC_CW = 8'h08;
  localparam logic [7:0] SRBS_ACC_CCW = 8'h0c;
  localparam logic [7:0] SRBS_DEC_CCW = 8'h10;
  localparam logic [7:0] SRBS_JERK = 8'h14;
  localparam logic [7:0] SRBS_BRK_DEC = 8'h18;
  localparam logic [7:0] SRBS_BRK_SPD = 8'h1c;
  localparam logic [7:0] SRBS_T_ENG = 8'h20;
  localparam logic [7:0] SRBS_T_REL = 8'h24;
  localparam logic [7:0] SRBS_CUR_OFS = 8'h28;
  localparam logic [7:0] SRBS_TARGET = 8'h2c;
  localparam logic [7:0] SRBS_STATUS = 8'h30;
  localparam logic [7:0] SRBS_REFOUT = 8'h34;
  // Control bit positions
  localparam int CB_RAMP_EN = 0;
  localparam int CB_SPROF = 1;
  localparam int CB_SPEED_CTL = 2;
  localparam int CB_BRAKE_EN = 3;
  localparam int CB_PIN_BRAKE = 4;
  localparam int CB_SWITCH_ON = 5;
  localparam int CB_COG_EN = 6;
  localparam int CB_COG_MAP = 7;
  localparam int CB_PIN_LEVEL = 8;
  // Brake time limits in ms and clock rate
  localparam int T_MIN_MS = 10;
  localparam int T_MAX_MS = 2000;
  localparam int CLK_HZ = 100000000;
  localparam logic [16:0] CYC_PER_MS = 17'(CLK_HZ / 1000);
  // Ramp update tick: rates are per second, the tick is 1 ms
  localparam logic [10:0] TICKS_PER_S = 11'd1000;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
  typedef enum logic [4:0] {
    SRBS_OFF = 5'b00001,
    SRBS_RELEASE = 5'b00010,
    SRBS_RUN = 5'b00100,
    SRBS_STOPPING = 5'b01000,
    SRBS_ENGAGE = 5'b10000
  } srbs_state_e;
endpackage

// ---- sim/srbs_motor_model.sv ----
`timescale 1ns/100ps
// Motor with holding brake and feedback encoder, as the drive sees it
module srbs_motor_model (
  input wire logic clk_sys,
  input wire logic indexFit,
  input wire logic brake_output_pin,
  input wire logic signed [31:0] speedRef,
  output logic encHasZeroIndex,
  output logic signed [31:0] shaftSpeed
);
  // Shaft is locked while the brake is engaged, else follows the reference
  always_ff @(posedge clk_sys) begin
    if (brake_output_pin) begin
      shaftSpeed <= speedRef;
    end else begin
      shaftSpeed <= 32'sh0;
    end
  end
  // Encoder kind is fixed by the fitted hardware, never by the drive
  assign encHasZeroIndex = indexFit;
endmodule

// ---- sim/srbs_sva.sv ----
`timescale 1ns/100ps
// Bus handshake and brake sequencing checks on the top ports
module srbs_sva (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic encHasZeroIndex,
  input wire logic signed [15:0] currentOffset,
  input wire logic holdTorque,
  input wire logic regulateEn,
  input wire logic powerStageOn,
  input wire logic brake_output_pin,
  input wire logic cogMapActive
);
  import srbs_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Request steps on the two bus halves
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_resp;
    s_wr_taken |=> !s_axi_awready ##1 s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
  property p_wr_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_wr_done: assert property (p_wr_done) else $error("write answer stuck");
  property p_rd_resp;
    s_rd_taken |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
  property p_rd_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_rd_done: assert property (p_rd_done) else $error("read answer stuck");
  // Holes past the last register answer with an error and zero data
  property p_rd_unmap;
    s_rd_taken ##0 (s_axi_araddr > SRBS_REFOUT) |=>
      s_axi_rresp == AXI_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read accepted");
  ////////////////////////////////////////
  // Brake and power sequencing
  property p_rst_out;
    $fell(rst) |-> !brake_output_pin && !powerStageOn && !holdTorque;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not idle after reset");
  property p_ofs_hold;
    currentOffset != 16'sh0 |-> holdTorque && !regulateEn && powerStageOn;
  endproperty
  a_ofs_hold: assert property (p_ofs_hold) else $error("offset outside release");
  property p_hold_on;
    holdTorque |-> powerStageOn;
  endproperty
  a_hold_on: assert property (p_hold_on) else $error("torque held while off");
  property p_reg_on;
    regulateEn |-> powerStageOn && !holdTorque;
  endproperty
  a_reg_on: assert property (p_reg_on) else $error("regulation while off");
  // Abort may lag the index line by a register stage or two
  property p_map_abort;
    !encHasZeroIndex [*3] |-> !cogMapActive;
  endproperty
  a_map_abort: assert property (p_map_abort) else $error("mapping not aborted");
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/100ps
module tb;
  import srbs_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awAddr = 8'h0, arAddr = 8'h0;
  logic [31:0] wData = 32'h0;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic indexFit = 1'b1;
  logic awReady, wReady, bValid, arReady, rValid, encIdx, brakePin;
  logic holdTorque, regulateEn, powerStageOn, cogCompEn, cogMapActive;
  logic [1:0] bResp, rResp;
  logic [31:0] rData;
  logic signed [31:0] speedRef;
  logic signed [15:0] currentOffset;
  int badCount = 0;
  int cmpCount = 0;
  int cycles = 0;
  always #5 clk_sys = ~clk_sys;
  srbs_top srbs_top_i (.clk_sys, .rst, .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .encHasZeroIndex(encIdx), .speedRef, .currentOffset, .holdTorque, .regulateEn,
    .powerStageOn, .brake_output_pin(brakePin), .cogCompEn, .cogMapActive);
  srbs_motor_model srbs_motor_model_i (.clk_sys, .indexFit, .brake_output_pin(brakePin),
    .speedRef, .encHasZeroIndex(encIdx), .shaftSpeed());
  ////////////////////////////////////////
  // Verdict, comparison and bus tasks
  task automatic finishTest();
    if (badCount == 0 && cmpCount > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      badCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Address and data offered together, each dropped once its ready is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_sys);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
    end while (!bValid);
    bReady <= 1'b0;
    chk({30'h0, bResp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk_sys);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arReady) arValid <= 1'b0;
    end while (!rValid);
    rReady <= 1'b0;
    chk(rData, ed);
    chk({30'h0, rResp}, {30'h0, er});
  endtask
  task automatic settle();
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic doReset();
    rst <= 1'b1;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
  endtask
  ////////////////////////////////////////
  // Scenarios
  task automatic testReset();
    chk({29'h0, brakePin, powerStageOn, holdTorque}, 32'h0);
    rd(SRBS_T_ENG, 32'd10, AXI_OKAY);
    rd(SRBS_CTRL, 32'h0, AXI_OKAY);
  endtask
  // Distinct values show the direction sets are kept apart
  task automatic testRegs();
    for (int i = 0; i < 6; i++) wr(SRBS_ACC_CW + 8'(4 * i), 32'h100 + 32'(i), AXI_OKAY);
    for (int i = 0; i < 6; i++) rd(SRBS_ACC_CW + 8'(4 * i), 32'h100 + 32'(i), AXI_OKAY);
    wr(SRBS_T_ENG, 32'd5, AXI_OKAY);
    rd(SRBS_T_ENG, 32'd10, AXI_OKAY);
    wr(SRBS_T_REL, 32'd3000, AXI_OKAY);
    rd(SRBS_T_REL, 32'd2000, AXI_OKAY);
    wr(SRBS_STATUS, 32'h1, AXI_SLVERR);
    wr(8'h40, 32'h1, AXI_SLVERR);
    rd(8'h40, 32'h0, AXI_SLVERR);
  endtask
  task automatic testRamp();
    wr(SRBS_CTRL, 32'h24, AXI_OKAY);
    wr(SRBS_TARGET, 32'd500, AXI_OKAY);
    settle();
    chk(speedRef, 32'd500);
    wr(SRBS_CTRL, 32'h21, AXI_OKAY);
    wr(SRBS_TARGET, 32'hfffffd44, AXI_OKAY);
    settle();
    chk(speedRef, 32'hfffffd44);
    wr(SRBS_CTRL, 32'h25, AXI_OKAY);
    wr(SRBS_TARGET, 32'd900, AXI_OKAY);
    settle();
    chk({31'h0, speedRef == 32'd900}, 32'h0);
  endtask
  // Release phase lasts milliseconds, so only its opening is judged here
  task automatic testBrake();
    wr(SRBS_CTRL, 32'h0, AXI_OKAY);
    wr(SRBS_CUR_OFS, 32'h0000ff38, AXI_OKAY);
    wr(SRBS_CTRL, 32'h3c, AXI_OKAY);
    settle();
    chk({28'h0, brakePin, holdTorque, regulateEn, powerStageOn}, 32'hd);
    chk({16'h0, currentOffset}, 32'h0000ff38);
    doReset();
    wr(SRBS_CUR_OFS, 32'h0000ff38, AXI_OKAY);
    wr(SRBS_CTRL, 32'h38, AXI_OKAY);
    settle();
    chk({13'h0, holdTorque, regulateEn, powerStageOn, currentOffset}, 32'h30000);
    wr(SRBS_CTRL, 32'h18, AXI_OKAY);
    settle();
    chk({30'h0, holdTorque, powerStageOn}, 32'h0);
  endtask
  task automatic testPinMux();
    wr(SRBS_CTRL, 32'h100, AXI_OKAY);
    settle();
    chk({31'h0, brakePin}, 32'h1);
    wr(SRBS_CTRL, 32'h110, AXI_OKAY);
    settle();
    chk({31'h0, brakePin}, 32'h0);
  endtask
  task automatic testCog();
    wr(SRBS_CTRL, 32'hc0, AXI_OKAY);
    settle();
    chk({30'h0, cogCompEn, cogMapActive}, 32'h3);
    indexFit <= 1'b0;
    settle();
    chk({31'h0, cogMapActive}, 32'h0);
    rd(SRBS_STATUS, 32'h80, AXI_OKAY);
    wr(SRBS_CTRL, 32'h0, AXI_OKAY);
    settle();
    chk({31'h0, cogCompEn}, 32'h0);
  endtask
  // Main sequence and hang guard
  initial begin
    doReset();
    testReset();
    testRegs();
    testRamp();
    testBrake();
    testPinMux();
    testCog();
    finishTest();
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      badCount++;
      finishTest();
    end
  end
endmodule
bind srbs_top srbs_sva srbs_sva_i (.clk_sys, .rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .encHasZeroIndex, .currentOffset, .holdTorque, .regulateEn,
  .powerStageOn, .brake_output_pin, .cogMapActive);
